// ===== rtl/iorb_pin_path.sv
`default_nettype none
module iorb_pin_path
  import iorb_pkg::*;
(
  input wire logic pin_sync_i,
  input wire logic [1:0] func_i,
  input wire logic rb_en_i,
  input wire logic is_reset_pin_i,
  input wire logic chan_sel_i,
  output logic rd_bit_o,
  output logic an_on_o
);
  wire is_analog = (func_i == IORB_FN_ANALOG);
  wire is_dout = (func_i == IORB_FN_DOUT);
  wire masked = is_analog | is_dout | is_reset_pin_i;
  // Readback returns pin level; otherwise per-function mask
  assign rd_bit_o = rb_en_i ? pin_sync_i
                  : (masked ? 1'b0 : pin_sync_i);
  // Analog switch forced on for the selected channel in readback
  assign an_on_o = is_analog | (rb_en_i & chan_sel_i);
endmodule
`default_nettype wire

// ===== rtl/iorb_pkg.sv
`default_nettype none
package iorb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register map, byte addresses on the plain port
  localparam logic [ADDR_W-1:0] OFF_PA_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PA_DIR = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PB_DATA = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_PB_DIR = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_RB_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_PA_FUNC_LO = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_PA_FUNC_HI = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_PB_FUNC_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_PB_FUNC_HI = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_PA_WAKE_EN = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_ADC_CHAN = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hb;
  localparam logic [ADDR_W-1:0] OFF_BIT_OP = 4'hc;
  localparam logic [DATA_W-1:0] RB_KEY = 8'hca;
  localparam logic [DATA_W-1:0] RB_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] PORT_RST = 8'hff;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // Bit-op command: [7] set/clear, [4] port B, [3] direction, [2:0] bit
  localparam int BOP_SET = 7;
  localparam int BOP_PORTB = 4;
  localparam int BOP_DIR = 3;
  localparam int BOP_IDX_LSB = 0;
  localparam int BOP_IDX_W = 3;
  localparam int ST_RB = 0;
  localparam int ST_WAKE = 1;
  // Per-pin shared function, two bits each
  typedef enum logic [1:0] {
    IORB_FN_IO,
    IORB_FN_SERIAL,
    IORB_FN_DOUT,
    IORB_FN_ANALOG
  } iorb_func_e;
endpackage
`default_nettype wire

// ===== rtl/iorb_top.sv
// The strobed register port and the register addresses were left to the implementer.
`default_nettype none
module iorb_top
  import iorb_pkg::*;
#(
  parameter int PINS = 8,
  parameter int RESET_PIN = 7
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [iorb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [iorb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [iorb_pkg::DATA_W-1:0] rdata_o,
  input wire logic [7:0] pa_pin_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pa_pin_oe_o,
  input wire logic [7:0] pb_pin_i,
  output logic [7:0] pb_pin_o,
  output logic [7:0] pb_pin_oe_o,
  input wire logic [7:0] pa_alt_o_i,
  input wire logic [7:0] pb_alt_o_i,
  input wire logic sleep_i,
  output logic [7:0] pa_an_on_o,
  output logic [7:0] pb_an_on_o,
  output logic wake_o,
  output logic readback_enable_internal_o
);
  import iorb_pkg::*;

  if (PINS != DATA_W) begin : g_bad_pins
    $error("PINS must equal DATA_W");
  end
  if (RESET_PIN < 0 || RESET_PIN >= PINS) begin : g_bad_reset_pin
    $error("RESET_PIN out of range");
  end

  logic [7:0] pa_data_q, pa_dir_q, pb_data_q, pb_dir_q;
  logic [7:0] rb_ctrl_q;
  logic rb_en_q;
  logic [15:0] pa_func_q, pb_func_q;
  logic [7:0] pa_wake_en_q;
  logic [3:0] adc_chan_q;
  logic wake_q;
  logic [7:0] rdata_q;
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q, pa_prev_q;

  // Pins are asynchronous to the core clock
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pa_s1_q <= ZERO_BYTE;
      pa_s2_q <= ZERO_BYTE;
      pb_s1_q <= ZERO_BYTE;
      pb_s2_q <= ZERO_BYTE;
      pa_prev_q <= ZERO_BYTE;
    end else begin
      pa_s1_q <= pa_pin_i;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= pb_pin_i;
      pb_s2_q <= pb_s1_q;
      pa_prev_q <= pa_s2_q;
    end
  end

  wire [7:0] pa_rd, pb_rd, pa_an, pb_an;
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      wire [1:0] fa = pa_func_q[2*g +: 2];
      wire [1:0] fb = pb_func_q[2*g +: 2];
      iorb_pin_path u_pa (
        .pin_sync_i(pa_s2_q[g]),
        .func_i(fa),
        .rb_en_i(rb_en_q),
        .is_reset_pin_i(1'b0),
        .chan_sel_i(adc_chan_q == 4'(g)),
        .rd_bit_o(pa_rd[g]),
        .an_on_o(pa_an[g])
      );
      iorb_pin_path u_pb (
        .pin_sync_i(pb_s2_q[g]),
        .func_i(fb),
        .rb_en_i(rb_en_q),
        .is_reset_pin_i(g == RESET_PIN),
        .chan_sel_i(adc_chan_q == 4'(g + PINS)),
        .rd_bit_o(pb_rd[g]),
        .an_on_o(pb_an[g])
      );
      // Shared function selects the driver; direction 0 means output
      wire fa_out = (fa == IORB_FN_DOUT) | (fa == IORB_FN_SERIAL);
      wire fb_out = (fb == IORB_FN_DOUT) | (fb == IORB_FN_SERIAL);
      assign pa_pin_o[g] = fa_out ? pa_alt_o_i[g] : pa_data_q[g];
      assign pb_pin_o[g] = fb_out ? pb_alt_o_i[g] : pb_data_q[g];
      assign pa_pin_oe_o[g] = (fa == IORB_FN_DOUT) |
                              ((fa == IORB_FN_IO) & ~pa_dir_q[g]);
      assign pb_pin_oe_o[g] = (fb == IORB_FN_DOUT) |
                              ((fb == IORB_FN_IO) & ~pb_dir_q[g] &
                               (g != RESET_PIN));
    end
  endgenerate

  assign pa_an_on_o = pa_an;
  assign pb_an_on_o = pb_an;

  // Bus decode
  wire wr_pa_d = wr_i & (addr_i == OFF_PA_DATA);
  wire wr_pa_c = wr_i & (addr_i == OFF_PA_DIR);
  wire wr_pb_d = wr_i & (addr_i == OFF_PB_DATA);
  wire wr_pb_c = wr_i & (addr_i == OFF_PB_DIR);
  wire wr_rb = wr_i & (addr_i == OFF_RB_CTRL);
  wire wr_bop = wr_i & (addr_i == OFF_BIT_OP);

  // Bit op: the port's read value is the base, as the core would see it
  wire bop_set = wdata_i[BOP_SET];
  wire bop_pb = wdata_i[BOP_PORTB];
  wire bop_dir = wdata_i[BOP_DIR];
  wire [2:0] bop_idx = wdata_i[BOP_IDX_LSB +: BOP_IDX_W];
  wire [7:0] bop_mask = 8'h01 << bop_idx;
  wire [7:0] bop_base = bop_dir ? (bop_pb ? pb_dir_q : pa_dir_q)
                                : (bop_pb ? pb_rd : pa_rd);
  wire [7:0] bop_new = bop_set ? (bop_base | bop_mask)
                               : (bop_base & ~bop_mask);
  wire bop_pa_d = wr_bop & ~bop_pb & ~bop_dir;
  wire bop_pa_c = wr_bop & ~bop_pb & bop_dir;
  wire bop_pb_d = wr_bop & bop_pb & ~bop_dir;
  wire bop_pb_c = wr_bop & bop_pb & bop_dir;

  // Ports reset to all ones: inputs, data high
  wire pa_data_we = wr_pa_d | bop_pa_d;
  wire pa_dir_we = wr_pa_c | bop_pa_c;
  wire pb_data_we = wr_pb_d | bop_pb_d;
  wire pb_dir_we = wr_pb_c | bop_pb_c;
  wire [7:0] pa_data_d = wr_pa_d ? wdata_i : bop_new;
  wire [7:0] pa_dir_d = wr_pa_c ? wdata_i : bop_new;
  wire [7:0] pb_data_d = wr_pb_d ? wdata_i : bop_new;
  wire [7:0] pb_dir_d = wr_pb_c ? wdata_i : bop_new;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pa_data_q <= PORT_RST;
    else if (pa_data_we) pa_data_q <= pa_data_d;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pa_dir_q <= PORT_RST;
    else if (pa_dir_we) pa_dir_q <= pa_dir_d;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pb_data_q <= PORT_RST;
    else if (pb_data_we) pb_data_q <= pb_data_d;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pb_dir_q <= PORT_RST;
    else if (pb_dir_we) pb_dir_q <= pb_dir_d;
  end

  // Enable recomputed on every write so leaving is immediate
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rb_ctrl_q <= RB_CTRL_RST;
      rb_en_q <= 1'b0;
    end else if (wr_rb) begin
      rb_ctrl_q <= wdata_i;
      rb_en_q <= (wdata_i == RB_KEY);
    end
  end
  assign readback_enable_internal_o = rb_en_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pa_func_q <= '0;
      pb_func_q <= '0;
      pa_wake_en_q <= ZERO_BYTE;
      adc_chan_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        OFF_PA_FUNC_LO: pa_func_q[7:0] <= wdata_i;
        OFF_PA_FUNC_HI: pa_func_q[15:8] <= wdata_i;
        OFF_PB_FUNC_LO: pb_func_q[7:0] <= wdata_i;
        OFF_PB_FUNC_HI: pb_func_q[15:8] <= wdata_i;
        OFF_PA_WAKE_EN: pa_wake_en_q <= wdata_i;
        OFF_ADC_CHAN: adc_chan_q <= wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // Falling edge on an enabled port A pin while asleep
  wire [7:0] pa_fall = pa_prev_q & ~pa_s2_q & pa_wake_en_q;
  wire wake_d = sleep_i & (|pa_fall);
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wake_q <= 1'b0;
    else wake_q <= wake_d;
  end
  assign wake_o = wake_q;

  wire [7:0] status = {6'h00, wake_q, rb_en_q};
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_i)
      OFF_PA_DATA: rd_mux = pa_rd;
      OFF_PA_DIR: rd_mux = pa_dir_q;
      OFF_PB_DATA: rd_mux = pb_rd;
      OFF_PB_DIR: rd_mux = pb_dir_q;
      OFF_RB_CTRL: rd_mux = rb_ctrl_q;
      OFF_PA_FUNC_LO: rd_mux = pa_func_q[7:0];
      OFF_PA_FUNC_HI: rd_mux = pa_func_q[15:8];
      OFF_PB_FUNC_LO: rd_mux = pb_func_q[7:0];
      OFF_PB_FUNC_HI: rd_mux = pb_func_q[15:8];
      OFF_PA_WAKE_EN: rd_mux = pa_wake_en_q;
      OFF_ADC_CHAN: rd_mux = {4'h0, adc_chan_q};
      OFF_STATUS: rd_mux = status;
      default: rd_mux = ZERO_BYTE;
    endcase
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rdata_q <= ZERO_BYTE;
    else if (rd_i) rdata_q <= rd_mux;
    else rdata_q <= ZERO_BYTE;
  end
  assign rdata_o = rdata_q;

  a_rb_enable_key: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rb_en_q == (rb_ctrl_q == RB_KEY))
    else $error("readback enable does not match key");
  a_rb_write_eval: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) wr_rb |=> (rb_en_q == ($past(wdata_i) == RB_KEY)))
    else $error("readback enable not updated on write");
  a_read_pin_rb: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PA_DATA && rb_en_q
      |=> rdata_o == $past(pa_s2_q))
    else $error("readback read not pin level");
  a_read_mask_off: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PA_DATA && !rb_en_q
      && pa_func_q[1:0] == IORB_FN_ANALOG |=> rdata_o[0] == 1'b0)
    else $error("analog pin not read as zero");
  a_an_path_off: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !rb_en_q && pa_func_q[1:0] != IORB_FN_ANALOG
      |-> !pa_an_on_o[0])
    else $error("analog path on without selection");
  a_an_path_forced: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rb_en_q && adc_chan_q == 4'h0 |-> pa_an_on_o[0])
    else $error("selected channel not forced on");
  a_bitop_rmw: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) bop_pa_c |=> pa_dir_q == $past(bop_new))
    else $error("bit op did not write full byte");
  a_wake_fall: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) sleep_i && (|pa_fall) |=> wake_o)
    else $error("missed wake on falling edge");
  a_out_default: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pa_func_q[1:0] == IORB_FN_IO
      && pa_pin_oe_o[0] |-> pa_pin_o[0] == pa_data_q[0])
    else $error("output pin not driving data bit");

  // Reset values are seen at the first edge after release
  a_port_reset_ones: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> pa_data_q == PORT_RST && pa_dir_q == PORT_RST
      && pb_data_q == PORT_RST && pb_dir_q == PORT_RST)
    else $error("port registers not all ones after reset");
  a_rb_nonkey_off: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rb_ctrl_q != RB_KEY
      |-> !readback_enable_internal_o)
    else $error("readback enabled without key");

  a_read_pin_rb_pb: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PB_DATA && rb_en_q
      |=> rdata_o == $past(pb_s2_q))
    else $error("port B readback read not pin level");
  a_read_io_pin: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PA_DATA && !rb_en_q
      && pa_func_q[1:0] == IORB_FN_IO |=> rdata_o[0] == $past(pa_s2_q[0]))
    else $error("plain pin not read as level");
  a_read_serial_pin: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PA_DATA && !rb_en_q
      && pa_func_q[3:2] == IORB_FN_SERIAL
      |=> rdata_o[1] == $past(pa_s2_q[1]))
    else $error("serial pin not read as level");
  a_read_dout_zero: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PA_DATA && !rb_en_q
      && pa_func_q[5:4] == IORB_FN_DOUT |=> rdata_o[2] == 1'b0)
    else $error("digital output pin not read as zero");
  a_read_reset_pin: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rd_i && addr_i == OFF_PB_DATA && !rb_en_q
      |=> rdata_o[RESET_PIN] == 1'b0)
    else $error("reset pin not read as zero");

  a_an_path_sel: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pa_func_q[1:0] == IORB_FN_ANALOG
      |-> pa_an_on_o[0])
    else $error("analog path off although selected");
  a_an_off_pb: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !rb_en_q && pb_func_q[1:0] != IORB_FN_ANALOG
      |-> !pb_an_on_o[0])
    else $error("port B analog path on without selection");
  a_an_forced_pb: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) rb_en_q && adc_chan_q == 4'(PINS)
      |-> pb_an_on_o[0])
    else $error("port B selected channel not forced on");

  a_dout_drives_alt: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pa_func_q[1:0] == IORB_FN_DOUT
      |-> pa_pin_oe_o[0] && pa_pin_o[0] == pa_alt_o_i[0])
    else $error("digital output pin not driving peripheral value");
  a_serial_undriven: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pa_func_q[1:0] == IORB_FN_SERIAL
      |-> !pa_pin_oe_o[0])
    else $error("serial pin driven by port logic");
  a_reset_pin_undriven: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pb_func_q[2*RESET_PIN +: 2] == IORB_FN_IO
      |-> !pb_pin_oe_o[RESET_PIN])
    else $error("reset pin driven as plain output");
  a_out_default_pb: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pb_func_q[1:0] == IORB_FN_IO
      && pb_pin_oe_o[0] |-> pb_pin_o[0] == pb_data_q[0])
    else $error("port B output pin not driving data bit");

  a_bitop_data: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) bop_pa_d |=> pa_data_q == $past(bop_new))
    else $error("bit op on data did not write full byte");
  a_bitop_pb_dir: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) bop_pb_c |=> pb_dir_q == $past(bop_new))
    else $error("bit op on port B direction lost");
  a_wake_awake: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !sleep_i |=> !wake_o)
    else $error("wake while not asleep");
  a_wake_enable: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !(|pa_fall) |=> !wake_o)
    else $error("wake without enabled falling edge");
endmodule
`default_nettype wire

// ===== test/iorb_ext_model.sv
`default_nettype none
module iorb_ext_model (
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device wins where it drives, else the outside circuit sets the level
  assign lvl_o = (oe_i & pin_o_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ===== test/tb_io_port_readback_selftest.sv
`default_nettype none
module tb_io_port_readback_selftest;
  timeunit 1ns;
  timeprecision 1ps;
  import iorb_pkg::*;
  int bad_count = 0;
  int num_checks = 0;
  int ch;
  int n;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slp = 1'b0;
  logic wk, rbe;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, ea = 8'hff, eb = 8'hff, alta = 8'h00, altb = 8'h00;
  logic [7:0] rdat, pa_o, pa_oe, pb_o, pb_oe, pa_l, pb_l, pa_an, pb_an, v, w;
  logic [15:0] fa, fb;
  logic [7:0] dir_m [2];

  initial begin
    forever #2 clk = ~clk;
  end

  iorb_top #(.PINS(8), .RESET_PIN(7)) i_dut (
    .core_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .pa_pin_i(pa_l), .pa_pin_o(pa_o),
    .pa_pin_oe_o(pa_oe), .pb_pin_i(pb_l), .pb_pin_o(pb_o),
    .pb_pin_oe_o(pb_oe), .pa_alt_o_i(alta), .pb_alt_o_i(altb),
    .sleep_i(slp), .pa_an_on_o(pa_an), .pb_an_on_o(pb_an), .wake_o(wk),
    .readback_enable_internal_o(rbe));
  iorb_ext_model i_ext_a (.pin_o_i(pa_o), .oe_i(pa_oe), .ext_i(ea),
    .lvl_o(pa_l));
  iorb_ext_model i_ext_b (.pin_o_i(pb_o), .oe_i(pb_oe), .ext_i(eb),
    .lvl_o(pb_l));

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask

  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Output, analog and reset-pin roles hide the pin unless readback is on
  function automatic logic [7:0] exp_port(logic [15:0] f, logic [7:0] l,
                                          logic rb, logic isb);
    logic [7:0] r;
    r = l;
    for (int i = 0; i < 8; i++) begin
      if (!rb && (f[2*i+1] || (isb && i == 7))) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] exp_an(logic [15:0] f, int c, logic rb,
                                        int base);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = (f[2*i+:2] == 2'b11) || (rb && c == base + i);
    end
    return r;
  endfunction

  // Digital-out pins drive the peripheral value; serial ones stay undriven
  function automatic logic [7:0] exp_oe(logic [15:0] f);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = (f[2*i+:2] == 2'b10);
    end
    return r;
  endfunction

  function automatic logic [7:0] exp_o(logic [15:0] f, logic [7:0] alt,
                                       logic [7:0] dat);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = (f[2*i+:2] == 2'b10 || f[2*i+:2] == 2'b01) ? alt[i] : dat[i];
    end
    return r;
  endfunction

  initial begin
    void'($urandom(24));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pa_oe", pa_oe, 8'h00);
    chk("pa_o", pa_o, PORT_RST);
    chk("pb_oe", pb_oe, 8'h00);
    rd_reg(OFF_PA_DIR, v);
    chk("pa_dir", v, PORT_RST);
    rd_reg(OFF_RB_CTRL, v);
    chk("rb_ctrl", v, RB_CTRL_RST);
    wr_reg(OFF_PA_DIR, ZERO_BYTE);
    #1;
    chk("pa_oe", pa_oe, 8'hff);
    chk("pa_o", pa_o, PORT_RST);
    wr_reg(OFF_PA_DATA, 8'h5a);
    repeat (4) @(posedge clk);
    rd_reg(OFF_PA_DATA, v);
    chk("pa_drive", v, 8'h5a);
    wr_reg(OFF_PA_DIR, PORT_RST);
    for (int i = 0; i <= 8; i++) begin
      v = (i == 8) ? RB_KEY : RB_KEY ^ (8'h01 << i);
      wr_reg(OFF_RB_CTRL, v);
      #1;
      chk("rb_en", {7'h0, rbe}, {7'h0, i == 8});
      rd_reg(OFF_RB_CTRL, w);
      chk("rb_ctrl", w, v);
    end
    for (int k = 0; k < 10; k++) begin
      fa = 16'($urandom);
      fb = 16'($urandom);
      ch = (k == 1) ? 0 : $urandom_range(15, 0);
      w = 8'($urandom);
      wr_reg(OFF_PA_FUNC_LO, fa[7:0]);
      wr_reg(OFF_PA_FUNC_HI, fa[15:8]);
      wr_reg(OFF_PB_FUNC_LO, fb[7:0]);
      wr_reg(OFF_PB_FUNC_HI, fb[15:8]);
      wr_reg(OFF_ADC_CHAN, 8'(ch));
      wr_reg(OFF_RB_CTRL, k[0] ? RB_KEY : (w == RB_KEY ? ZERO_BYTE : w));
      ea <= 8'($urandom);
      eb <= 8'($urandom);
      alta <= 8'($urandom);
      altb <= 8'($urandom);
      repeat (4) @(posedge clk);
      rd_reg(OFF_PA_DATA, v);
      chk("pa_port", v, exp_port(fa, pa_l, k[0], 1'b0));
      rd_reg(OFF_PB_DATA, v);
      chk("pb_port", v, exp_port(fb, pb_l, k[0], 1'b1));
      chk("pa_an", pa_an, exp_an(fa, ch, k[0], 0));
      chk("pb_an", pb_an, exp_an(fb, ch, k[0], 8));
      chk("pa_oe", pa_oe, exp_oe(fa));
      chk("pb_oe", pb_oe, exp_oe(fb));
      chk("pa_o", pa_o, exp_o(fa, alta, 8'h5a));
      chk("pb_o", pb_o, exp_o(fb, altb, PORT_RST));
      rd_reg(OFF_STATUS, v);
      chk("status", v, {7'h0, k[0]});
      chk("rb_en", {7'h0, rbe}, {7'h0, k[0]});
    end
    wr_reg(OFF_RB_CTRL, ZERO_BYTE);
    dir_m[0] = PORT_RST;
    dir_m[1] = PORT_RST;
    for (int k = 0; k < 12; k++) begin
      v = (8'($urandom) & 8'h97) | 8'h08;
      dir_m[v[4]][v[2:0]] = v[7];
      wr_reg(OFF_BIT_OP, v);
      rd_reg(OFF_PA_DIR, w);
      chk("pa_dir", w, dir_m[0]);
      rd_reg(OFF_PB_DIR, w);
      chk("pb_dir", w, dir_m[1]);
    end
    wr_reg(OFF_PA_FUNC_LO, ZERO_BYTE);
    wr_reg(OFF_PA_FUNC_HI, ZERO_BYTE);
    wr_reg(OFF_PA_DIR, PORT_RST);
    wr_reg(OFF_PA_WAKE_EN, 8'h10);
    // Enabled pin asleep, other pin asleep, enabled pin awake
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      ea <= PORT_RST;
      slp <= (k != 2);
      repeat (4) @(posedge clk);
      ea <= (k == 1) ? 8'hf7 : 8'hef;
      n = 0;
      repeat (10) begin
        @(posedge clk);
        #1;
        n += (wk === 1'b1);
      end
      chk("wake", 8'(n), {7'h0, k == 0});
    end
    slp <= 1'b0;
    // Data bit op takes the input pin levels as its base
    @(posedge clk);
    ea <= 8'h3c;
    repeat (4) @(posedge clk);
    wr_reg(OFF_BIT_OP, 8'h81);
    #1;
    chk("pa_rmw", pa_o, 8'h3e);
    wr_reg(OFF_BIT_OP, 8'h04);
    #1;
    chk("pa_rmw", pa_o, 8'h2c);
    wr_reg(OFF_PB_DATA, ZERO_BYTE);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pb_o", pb_o, PORT_RST);
    chk("pb_oe", pb_oe, 8'h00);
    chk("pa_o", pa_o, PORT_RST);
    rd_reg(OFF_PB_DIR, v);
    chk("pb_dir", v, PORT_RST);
    stop_test();
  end

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
